/* irqep_pkg.sv */
// Constants shared by the interrupt enable / priority register block
`default_nettype none
package irqep_pkg;
  // Register indices; the byte address on APB is four times the index
  localparam logic [7:0] IDX_ENABLE2 = 8'hB1; // Second enable register
  localparam logic [7:0] IDX_PRIO_UPPER = 8'hB7; // Priority-high register
  localparam logic [7:0] IDX_CTRL = 8'hC0; // Global enable and priority-low bits
  localparam logic [7:0] IDX_AUX_PRIO = 8'hC1; // Levels of pulse-measure and power-fail
  localparam logic [7:0] IDX_STATUS = 8'hC2; // Sticky event flags, cleared by read
  localparam logic [7:0] IDX_MASK = 8'hC3; // Interrupt mask, same layout as status
  localparam int ADDR_W = 12; // APB address width
  // Field positions of the second enable register
  localparam int EN2_PULSE = 0; // Pulse-measure enable
  localparam int EN2_CTR_LO = 1; // Counter channel 1 enable
  localparam int EN2_PF = 7; // Power-fail enable
  localparam logic [7:0] EN2_WMASK = 8'h9F; // Writable bits; 5 and 6 reserved
  localparam logic [7:0] PRIO_WMASK = 8'h7F; // Writable bits; 7 reserved
  localparam int CTRL_GIE = 7; // Global enable in control register
  localparam int GRP_COUNTER = 6; // Counter group position in priority registers
  localparam int NGRP = 7; // Priority groups
  // Source numbering, lower number wins a tie in level
  localparam int SRC_PULSE = 0; // Pulse-measure unit
  localparam int SRC_CTR1 = 1; // Counter channels occupy 1 to 4
  localparam int SRC_PF = 5; // Power-fail
  localparam int NSRC = 6; // Forwarded sources
  localparam logic [7:0] EN2_RST = 8'h00; // Reset values
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
endpackage : irqep_pkg
`default_nettype wire

/* irqep_arb_if.sv */
// Interface between register block and priority arbiter
`timescale 1ns/1ps
`default_nettype none
interface irqep_arb_if;
  logic [5:0] req; // Forwarded requests, one per source
  logic [6:0] prio_hi; // Priority-high bits per group
  logic [6:0] prio_lo; // Priority-low bits per group
  logic [3:0] aux_lvl; // Pulse-measure level [1:0], power-fail level [3:2]
  logic win_valid; // Some request pending
  logic [2:0] win_id; // Winning source
  logic [1:0] win_level; // Its level
  logic [13:0] grp_level; // Two-bit level of each group
  modport ctl (output req, prio_hi, prio_lo, aux_lvl, input win_valid, win_id, win_level,
    grp_level);
  modport arb (input req, prio_hi, prio_lo, aux_lvl, output win_valid, win_id, win_level,
    grp_level);
endinterface : irqep_arb_if
`default_nettype wire

/* irqep_arb.sv */
// Priority level forming and arbitration among forwarded requests
`timescale 1ns/1ps
`default_nettype none
module irqep_arb
  import irqep_pkg::*;
(
  irqep_arb_if.arb a
);
  // Level of every group: high bit above, low bit below
  genvar g;
  generate
    for (g = 0; g < NGRP; g++) begin : g_lvl
      assign a.grp_level[2*g+1 -: 2] = {a.prio_hi[g], a.prio_lo[g]};
    end
  endgenerate

  // Highest level wins; on equal level the lower source number is kept
  always_comb begin
    logic [1:0] lvl;
    lvl = 2'h0;
    a.win_valid = 1'b0;
    a.win_id = 3'h0;
    a.win_level = 2'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (i == SRC_PULSE) begin
        lvl = a.aux_lvl[1:0];
      end else if (i == SRC_PF) begin
        lvl = a.aux_lvl[3:2];
      end else begin
        lvl = a.grp_level[2*GRP_COUNTER+1 -: 2]; // Counters share the counter group level
      end
      if (a.req[i] && (!a.win_valid || lvl > a.win_level)) begin
        a.win_valid = 1'b1;
        a.win_id = 3'(i);
        a.win_level = lvl;
      end
    end
  end
endmodule : irqep_arb
`default_nettype wire

/* irqep_regs.sv */
// Interrupt enable and priority-high registers with APB slave and arbiter
`timescale 1ns/1ps
`default_nettype none
module irqep_regs
  import irqep_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] src_req,
  output logic [5:0] fwd_req,
  output logic [13:0] grp_level,
  output logic core_irq_req,
  output logic [2:0] core_irq_id,
  output logic [1:0] core_irq_level,
  output logic irq
);
  // Register state
  logic [7:0] en2_q, en2_d; // Second enable register
  logic [7:0] prio_q, prio_d; // Priority-high register
  logic [7:0] ctrl_q, ctrl_d; // Global enable and priority-low bits
  logic [7:0] aux_q, aux_d; // Extra source levels
  logic [5:0] stat_q, stat_d; // Sticky event flags
  logic [5:0] mask_q, mask_d; // Interrupt mask
  logic [31:0] prdata_q, prdata_d; // Read data
  logic pready_q, pready_d; // Access-phase answer
  logic pslverr_q, pslverr_d; // Unmapped address flag
  // Outputs toward the core
  logic [5:0] fwd_q, fwd_d; // Gated requests
  logic [13:0] lvl_q, lvl_d; // Group levels
  logic req_q, req_d; // Pending request to core
  logic [2:0] id_q, id_d; // Winning source
  logic [1:0] wl_q, wl_d; // Winning level
  logic irq_q, irq_d; // Level interrupt
  logic [5:0] en_bits; // Per-source enables in source order
  logic acc; // Completing access
  logic [7:0] rd8; // Selected register value

  irqep_arb_if ai ();

  // Arbiter works on the registered requests so levels and ids stay aligned
  irqep_arb u_arb (
    .a(ai.arb)
  );

  // Address decode used for both reads and writes
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    hit = (addr == {2'h0, idx, 2'h0});
  endfunction : hit

  assign acc = psel && penable && pready_q;
  assign en_bits = {en2_q[EN2_PF], en2_q[EN2_CTR_LO +: 4], en2_q[EN2_PULSE]};
  assign ai.req = fwd_q;
  assign ai.prio_hi = prio_q[6:0];
  assign ai.prio_lo = ctrl_q[6:0];
  assign ai.aux_lvl = aux_q[3:0];

  // Read mux; reserved bits are not stored so they read zero
  always_comb begin
    rd8 = 8'h00;
    if (hit(paddr, IDX_ENABLE2)) begin
      rd8 = en2_q & EN2_WMASK;
    end else if (hit(paddr, IDX_PRIO_UPPER)) begin
      rd8 = prio_q & PRIO_WMASK;
    end else if (hit(paddr, IDX_CTRL)) begin
      rd8 = ctrl_q;
    end else if (hit(paddr, IDX_AUX_PRIO)) begin
      rd8 = aux_q;
    end else if (hit(paddr, IDX_STATUS)) begin
      rd8 = {2'h0, stat_q};
    end else if (hit(paddr, IDX_MASK)) begin
      rd8 = {2'h0, mask_q};
    end
  end

  // Next state of registers, bus answer and core outputs
  always_comb begin
    en2_d = en2_q;
    prio_d = prio_q;
    ctrl_d = ctrl_q;
    aux_d = aux_q;
    mask_d = mask_q;
    stat_d = stat_q;
    // One wait state: answer in the second access cycle, then drop
    pready_d = psel && penable && !pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (psel && penable && !pready_q) begin
      prdata_d = {24'h0, rd8};
      pslverr_d = !(hit(paddr, IDX_ENABLE2) || hit(paddr, IDX_PRIO_UPPER) ||
        hit(paddr, IDX_CTRL) || hit(paddr, IDX_AUX_PRIO) || hit(paddr, IDX_STATUS) ||
        hit(paddr, IDX_MASK));
    end
    if (acc && pwrite) begin
      // Reserved positions are dropped so a stray one never reaches logic
      if (hit(paddr, IDX_ENABLE2)) en2_d = pwdata[7:0] & EN2_WMASK;
      if (hit(paddr, IDX_PRIO_UPPER)) prio_d = pwdata[7:0] & PRIO_WMASK;
      if (hit(paddr, IDX_CTRL)) ctrl_d = pwdata[7:0];
      if (hit(paddr, IDX_AUX_PRIO)) aux_d = {4'h0, pwdata[3:0]};
      if (hit(paddr, IDX_MASK)) mask_d = pwdata[5:0];
    end
    // Read clears status; a new event in the same cycle survives
    if (acc && !pwrite && hit(paddr, IDX_STATUS)) stat_d = 6'h00;
    // Forward only enabled requests, and only with global enable set
    fwd_d = src_req & en_bits & {NSRC{ctrl_q[CTRL_GIE]}};
    stat_d = stat_d | (fwd_d & ~fwd_q);
    irq_d = |(stat_d & mask_d);
    lvl_d = ai.grp_level;
    req_d = ai.win_valid;
    id_d = ai.win_id;
    wl_d = ai.win_level;
  end

  // Register stage, cleared to constants by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en2_q <= EN2_RST;
      prio_q <= PRIO_RST;
      ctrl_q <= CTRL_RST;
      aux_q <= AUX_RST;
      mask_q <= 6'h00;
      stat_q <= 6'h00;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      fwd_q <= 6'h00;
      lvl_q <= 14'h0000;
      req_q <= 1'b0;
      id_q <= 3'h0;
      wl_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      en2_q <= en2_d;
      prio_q <= prio_d;
      ctrl_q <= ctrl_d;
      aux_q <= aux_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      fwd_q <= fwd_d;
      lvl_q <= lvl_d;
      req_q <= req_d;
      id_q <= id_d;
      wl_q <= wl_d;
      irq_q <= irq_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fwd_req = fwd_q;
  assign grp_level = lvl_q;
  assign core_irq_req = req_q;
  assign core_irq_id = id_q;
  assign core_irq_level = wl_q;
  assign irq = irq_q;

  // Checks
  chk_pf_gate: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_q[SRC_PF] |-> $past(src_req[SRC_PF] && en2_q[EN2_PF]))
    else $error("power-fail forwarded without enable");
  chk_ctr_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ctrl_q[CTRL_GIE]) |-> fwd_q[4:1] == $past(src_req[4:1] & en2_q[4:1]))
    else $error("counter gating wrong");
  chk_pulse_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ctrl_q[CTRL_GIE] && src_req[SRC_PULSE] && en2_q[EN2_PULSE]) |-> fwd_q[SRC_PULSE])
    else $error("pulse-measure request dropped");
  chk_global_off: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q[CTRL_GIE] |=> fwd_q == 6'h00)
    else $error("request forwarded with global enable clear");
  chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    en2_q[6:5] == 2'h0 && !prio_q[7])
    else $error("reserved bit stored");
  chk_level_form: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 lvl_q[13:12] == $past({prio_q[6], ctrl_q[6]}))
    else $error("counter level not high over low");
  chk_winner_max: assert property (@(posedge pclk) disable iff (!presetn)
    $past(fwd_q[SRC_PF] && aux_q[3:2] == 2'h3) |-> req_q && wl_q == 2'h3)
    else $error("highest level not chosen");
  chk_prio_write: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && hit(paddr, IDX_PRIO_UPPER) |=> prio_q == $past(pwdata[7:0] & PRIO_WMASK))
    else $error("priority-high write lost");
  chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready_q |=> !pready_q)
    else $error("ready held two cycles");
  cov_pf_fwd: cover property (@(posedge pclk) disable iff (!presetn) fwd_q[SRC_PF]);
  cov_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_q));
  cov_two_pending: cover property (@(posedge pclk) disable iff (!presetn)
    fwd_q[SRC_PULSE] && fwd_q[SRC_CTR1]);
  cov_pf_wins: cover property (@(posedge pclk) disable iff (!presetn)
    req_q && id_q == 3'(SRC_PF) && wl_q == 2'h3);
  // A cleared enable must block the power-fail source on the next edge
  chk_pf_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    !en2_q[EN2_PF] |=> !fwd_q[SRC_PF])
    else $error("power-fail forwarded while disabled");
  // Reserved enable bits must come back as zero on every read
  chk_reserved_read: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && hit(paddr, IDX_ENABLE2) |-> prdata_q[6:5] == 2'h0)
    else $error("reserved enable bits read as one");
  // A new event must survive a read-clear of status in the same cycle
  chk_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    (fwd_d & ~fwd_q) != 6'h00 |=> (stat_q & $past(fwd_d & ~fwd_q)) == $past(fwd_d & ~fwd_q))
    else $error("new event lost from status");
endmodule : irqep_regs
`default_nettype wire

/* irqep_core_model.sv */
// Behavioural model of the core vectoring logic that consumes the winner
`timescale 1ns/1ps
`default_nettype none
module irqep_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic core_irq_req,
  input wire logic [2:0] core_irq_id,
  input wire logic [1:0] core_irq_level,
  output logic taken,
  output logic [2:0] taken_id,
  output logic [1:0] taken_level
);
  logic [1:0] wait_q; // Cycles the request has stood
  // Slow mode lets a request stand two cycles before the vector is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 2'h0;
      taken <= 1'b0;
      taken_id <= 3'h0;
      taken_level <= 2'h0;
    end else if (!core_irq_req) begin
      wait_q <= 2'h0;
    end else if (!slow || wait_q == 2'h2) begin
      taken <= 1'b1;
      taken_id <= core_irq_id;
      taken_level <= core_irq_level;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule : irqep_core_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the interrupt enable and priority register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import irqep_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, core_irq_req, irq, taken;
  logic [5:0] src_req = '0;
  logic [5:0] fwd_req;
  logic [13:0] grp_level;
  logic [2:0] core_irq_id, taken_id;
  logic [1:0] core_irq_level, taken_level;
  logic [31:0] lfsr = 32'hA8F8; // Fixed seed
  logic [7:0] en, ph, ct, ax; // Values last written to the registers
  logic [32:0] expq[$]; // Expected {slverr, data} of pending reads
  int n_fail = 0;
  int cmp_count = 0;
  always #2.5 pclk = ~pclk;
  irqep_regs irqep_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req), .fwd_req(fwd_req), .grp_level(grp_level),
    .core_irq_req(core_irq_req), .core_irq_id(core_irq_id), .core_irq_level(core_irq_level),
    .irq(irq));
  irqep_core_model irqep_core_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
    .core_irq_req(core_irq_req), .core_irq_id(core_irq_id), .core_irq_level(core_irq_level),
    .taken(taken), .taken_id(taken_id), .taken_level(taken_level));
  task automatic stop_test;
    $display("mismatches %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] rnd;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  // Level of a source: counters share the counter group, the others use aux
  function automatic logic [1:0] lv(input int s);
    if (s == SRC_PULSE) return ax[1:0];
    if (s == SRC_PF) return ax[3:2];
    return {ph[GRP_COUNTER], ct[GRP_COUNTER]};
  endfunction : lv
  // One APB transfer; a read files its expected answer for the monitor
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [32:0] exp);
    int k;
    if (!wr) expq.push_back(exp);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= exp[31:0];
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_fail++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Each completed read takes the oldest note off the queue
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (expq.size() == 0) n_fail++;
      else chk({pslverr, prdata}, expq.pop_front());
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle
  initial begin
    logic [7:0] idxs[6];
    logic [31:0] r;
    logic [5:0] f;
    int best;
    idxs = '{IDX_ENABLE2, IDX_PRIO_UPPER, IDX_CTRL, IDX_AUX_PRIO, IDX_STATUS, IDX_MASK};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (idxs[i]) apb(1'b0, idxs[i], 33'h0);
    apb(1'b1, IDX_ENABLE2, 33'hFF);
    apb(1'b0, IDX_ENABLE2, 33'h9F);
    apb(1'b1, IDX_PRIO_UPPER, 33'hFF);
    apb(1'b0, IDX_PRIO_UPPER, 33'h7F);
    apb(1'b0, 8'h10, {1'b1, 32'h0});
    // Sticky status, mask and read-to-clear, with a slow core
    ax = 8'h0C;
    apb(1'b1, IDX_AUX_PRIO, 33'h0C);
    apb(1'b1, IDX_CTRL, 33'h80);
    slow <= 1'b1;
    src_req <= 6'h21;
    settle(3);
    chk(irq, 1'b0);
    apb(1'b1, IDX_MASK, 33'h20);
    settle(2);
    chk(irq, 1'b1);
    chk({taken, taken_id, taken_level}, {1'b1, 3'(SRC_PF), 2'h3});
    apb(1'b0, IDX_STATUS, 33'h21);
    apb(1'b0, IDX_STATUS, 33'h00);
    settle(2);
    chk(irq, 1'b0);
    // Random enables, levels and requests
    for (int i = 0; i < 10; i++) begin
      en = rnd() & EN2_WMASK;
      ph = rnd() & PRIO_WMASK;
      ct = rnd();
      ax = rnd() & 8'h0F;
      if (i == 0) ct[CTRL_GIE] = 1'b0;
      apb(1'b1, IDX_ENABLE2, {25'h0, en});
      apb(1'b1, IDX_PRIO_UPPER, {25'h0, ph});
      apb(1'b1, IDX_CTRL, {25'h0, ct});
      apb(1'b1, IDX_AUX_PRIO, {25'h0, ax});
      r = rnd();
      @(posedge pclk);
      src_req <= r[5:0];
      slow <= r[6];
      settle(3);
      f = ct[CTRL_GIE] ? (r[5:0] & {en[EN2_PF], en[4:0]}) : 6'h00;
      chk(fwd_req, f);
      for (int g = 0; g < NGRP; g++) chk(grp_level[2*g +: 2], {ph[g], ct[g]});
      best = NSRC;
      for (int s = 0; s < NSRC; s++) if (f[s] && (best == NSRC || lv(s) > lv(best))) best = s;
      chk(core_irq_req, |f);
      if (|f) chk({core_irq_id, core_irq_level}, {best[2:0], lv(best)});
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
